// >>> verilog/udfr_pkg.sv
package udfr_pkg;
   // frequencies in 0.01 Hz units, 16 bits (0..400.00 Hz)
   localparam int FREQ_W = 16;
   localparam logic [3:0] FRQ_METHOD_UPDOWN = 4'h8;
   localparam logic [4:0] FUNC_UP = 5'h0F;
   localparam logic [4:0] FUNC_DOWN = 5'h10;
   localparam logic [4:0] FUNC_STOP3W = 5'h11;
   localparam logic [4:0] FUNC_PID_BYPASS = 5'h15;
   localparam logic [1:0] UDMODE_RAMP = 2'h0;
   localparam logic [1:0] UDMODE_STEP = 2'h1;
   localparam logic [1:0] UDMODE_COMBO = 2'h2;
   localparam logic [1:0] CTRL_SLIP_COMP = 2'h1;
   localparam logic [15:0] STEP_MAX = 16'h9C40;
   localparam logic [15:0] DWELL_FREQ_MIN = 16'h000A;
   localparam logic [15:0] PID_HIGH_DEFAULT = 16'h1770;
   localparam logic [15:0] PID_LOW_DEFAULT = 16'h0032;
   localparam logic [3:0] POLES_MIN = 4'h2;
   localparam logic [3:0] POLES_MAX = 4'hC;
   localparam logic [3:0] POLES_DEFAULT = 4'h4;
   localparam int SLIP_DIVISOR = 120;
   localparam int CLK_HZ = 40000000;
   localparam int HOLD_TIME_S = 3;
   localparam int HOLD_CYCLES = HOLD_TIME_S * CLK_HZ;
   localparam int DEBOUNCE_TIME_US = 1000;
   localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * (CLK_HZ / 1000000);
   localparam int TICK_TIME_MS = 10;
   localparam int TICK_CYCLES = TICK_TIME_MS * (CLK_HZ / 1000);
   typedef enum logic [1:0] {
      INERTIA_LOW = 2'b00,
      INERTIA_TEN = 2'b01,
      INERTIA_HIGH = 2'b10,
      INERTIA_BAD = 2'b11
   } udfr_inertia_e;
   typedef enum logic [1:0] {
      RUN_IDLE = 2'b00,
      RUN_DWELL = 2'b01,
      RUN_ACTIVE = 2'b10
   } udfr_run_e;
endpackage

// >>> verilog/udfr_debounce.sv
`timescale 1ns/1ps
module udfr_debounce #(
   parameter int CYCLES = 40000
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // raw and filtered level
   input wire logic rawIn,
   output logic cleanOut
);
   logic sync1_r;
   logic sync2_r;
   logic [31:0] cnt_r;
   wire differs = (sync2_r != cleanOut);
   wire settled = (cnt_r >= 32'(CYCLES - 1));

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         cnt_r <= 32'h0;
         cleanOut <= 1'b0;
      end
      else
      begin
         sync1_r <= rawIn;
         sync2_r <= sync1_r;
         cnt_r <= (differs && !settled) ? cnt_r + 32'h1 : 32'h0;
         if (differs && settled)
            cleanOut <= sync2_r;
      end
   end
endmodule

// >>> verilog/udfr_updown_freq_ref.sv
// Operation
// - up-down honoured only when method is 8
// - function 15 raises, 16 lowers frequency
// - mode 0: ramp up to max/upper limit
// - mode 0: ramp down to lower limit
// - mode 1: each rising edge steps one step
// - step size is step parameter, 0-400 Hz
// - mode 1: save reference at falling edge
// - stop keeps previous saved value only
// - mode 2: step, then ramp after 3 s
// - input during unfinished step is ignored
// - function 17 selects 3-wire stop button
// - 3-wire latches start, stop-off drops run
// - dwell frequency for dwell time at start
// - slip compensation only when control mode 1
// - slip = rated freq minus rpm*poles/120
// - inertia code 0/1/2 decoded to classes
// - PID output clamped between low/high limits
// - function 21 switches PID to normal
`timescale 1ns/1ps
module udfr_updown_freq_ref
   import udfr_pkg::*;
#(
   parameter int FW = FREQ_W,
   parameter int HOLD_CNT = HOLD_CYCLES,
   parameter int DEB_CNT = DEBOUNCE_CYCLES,
   parameter int TICK_CNT = TICK_CYCLES
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // terminals seven and eight, raw run command
   input wire logic termSeven,
   input wire logic termEight,
   input wire logic startButton,
   // settings
   input wire logic [3:0] freqSetMethod,
   input wire logic [4:0] terminal_seven_function,
   input wire logic [4:0] terminal_eight_function,
   input wire logic [1:0] updown_mode_select,
   input wire logic [FW-1:0] updown_step_freq,
   input wire logic updownSaveEnable,
   input wire logic [FW-1:0] maxFreq,
   input wire logic freqLimitEnable,
   input wire logic [FW-1:0] upperLimit,
   input wire logic [FW-1:0] lowerLimit,
   input wire logic [FW-1:0] rampStep,
   input wire logic [FW-1:0] dwell_frequency,
   input wire logic [7:0] dwell_time,
   input wire logic [1:0] control_mode_select,
   input wire logic [FW-1:0] ratedFreq,
   input wire logic [15:0] ratedRpm,
   input wire logic [3:0] motor_pole_count,
   input wire logic [1:0] load_inertia_code,
   input wire logic [FW-1:0] pidRawFreq,
   input wire logic [FW-1:0] pid_out_high_limit,
   input wire logic [FW-1:0] pid_out_low_limit,
   input wire logic pidEnable,
   // outputs
   output logic [FW-1:0] freqRef,
   output logic [FW-1:0] outFreq,
   output logic [FW-1:0] savedFreq,
   output logic runActive,
   output logic slipCompActive,
   output logic [FW-1:0] rated_slip_freq,
   output logic [1:0] inertiaClass,
   output logic [FW-1:0] pidOutFreq,
   output logic pidBypassed
);
   import udfr_pkg::*;

   function automatic logic [FW-1:0] clampf(input logic [FW-1:0] v, input logic [FW-1:0] lo,
                                            input logic [FW-1:0] hi);
      clampf = (v > hi) ? hi : ((v < lo) ? lo : v);
   endfunction

   function automatic logic hasFunc(input logic [4:0] code);
      hasFunc = (terminal_seven_function == code) || (terminal_eight_function == code);
   endfunction

   function automatic logic termFunc(input logic s7, input logic s8, input logic [4:0] code);
      termFunc = (s7 && terminal_seven_function == code) || (s8 && terminal_eight_function == code);
   endfunction

   // one bit of headroom so value or limit plus step cannot wrap before the compare
   function automatic logic [FW-1:0] addClamp(input logic [FW-1:0] a, input logic [FW-1:0] b,
                                              input logic [FW-1:0] hi);
      logic [FW:0] s;
      s = {1'b0, a} + {1'b0, b};
      addClamp = (s > {1'b0, hi}) ? hi : s[FW-1:0];
   endfunction

   function automatic logic [FW-1:0] subClamp(input logic [FW-1:0] a, input logic [FW-1:0] b,
                                              input logic [FW-1:0] lo);
      logic [FW:0] s;
      s = {1'b0, lo} + {1'b0, b};
      subClamp = ({1'b0, a} < s) ? lo : a - b;
   endfunction

   logic sevenClean;
   logic eightClean;
   logic startClean;

   udfr_debounce #(.CYCLES(DEB_CNT)) u_deb7 (.sys_clk(sys_clk), .nrst(nrst), .rawIn(termSeven),
      .cleanOut(sevenClean));
   udfr_debounce #(.CYCLES(DEB_CNT)) u_deb8 (.sys_clk(sys_clk), .nrst(nrst), .rawIn(termEight),
      .cleanOut(eightClean));
   udfr_debounce #(.CYCLES(DEB_CNT)) u_debs (.sys_clk(sys_clk), .nrst(nrst), .rawIn(startButton),
      .cleanOut(startClean));

   // terminal decode
   wire udEnabled = (freqSetMethod == FRQ_METHOD_UPDOWN);
   wire upIn = udEnabled && termFunc(sevenClean, eightClean, FUNC_UP);
   wire downIn = udEnabled && termFunc(sevenClean, eightClean, FUNC_DOWN);
   wire udDefined = hasFunc(FUNC_UP) || hasFunc(FUNC_DOWN);
   wire threeWire = hasFunc(FUNC_STOP3W);
   wire stopHeld = termFunc(sevenClean, eightClean, FUNC_STOP3W);
   wire bypassIn = termFunc(sevenClean, eightClean, FUNC_PID_BYPASS);

   logic upPrev_r;
   logic downPrev_r;
   logic startPrev_r;
   logic [31:0] holdCnt_r;
   logic holdDone_r;
   logic [31:0] tickCnt_r;
   logic [7:0] dwellCnt_r;
   logic [FW-1:0] target_r;
   logic [FW-1:0] stepGoal_r;
   logic stepBusy_r;
   udfr_run_e runState_r;

   wire upRise = upIn && !upPrev_r;
   wire downRise = downIn && !downPrev_r;
   wire upFall = !upIn && upPrev_r;
   wire downFall = !downIn && downPrev_r;
   wire anyRise = upRise || downRise;
   wire anyHeld = upIn || downIn;
   wire tick = (tickCnt_r >= 32'(TICK_CNT - 1));

   // effective limits
   wire [FW-1:0] hiLim = freqLimitEnable ? upperLimit : maxFreq;
   wire [FW-1:0] loLim = freqLimitEnable ? lowerLimit : '0;
   wire [FW-1:0] stepSz = (updown_step_freq > STEP_MAX) ? STEP_MAX : updown_step_freq;

   wire rampMode = (updown_mode_select == UDMODE_RAMP) ||
                   (updown_mode_select == UDMODE_COMBO && holdDone_r);
   wire stepMode = (updown_mode_select == UDMODE_STEP) || (updown_mode_select == UDMODE_COMBO);

   wire [FW-1:0] stepUp = addClamp(target_r, stepSz, hiLim);
   wire [FW-1:0] stepDn = subClamp(target_r, stepSz, loLim);
   wire [FW-1:0] rampUp = addClamp(target_r, rampStep, hiLim);
   wire [FW-1:0] rampDn = subClamp(target_r, rampStep, loLim);

   logic [FW-1:0] targetNxt;
   logic [FW-1:0] goalNxt;
   logic busyNxt;
   always_comb
   begin
      targetNxt = target_r;
      goalNxt = stepGoal_r;
      busyNxt = stepBusy_r;
      // up and down together cancel: neither ramp branch fires
      if (rampMode && tick && upIn && !downIn)
         targetNxt = rampUp;
      else if (rampMode && tick && downIn && !upIn)
         targetNxt = rampDn;
      else if (stepMode && !rampMode && anyRise && !stepBusy_r)
      begin
         goalNxt = upRise ? stepUp : stepDn;
         busyNxt = 1'b1;
      end
      if (stepBusy_r && tick)
      begin
         // step is applied through the ramp so it takes time to complete
         if (target_r < stepGoal_r)
            targetNxt = addClamp(target_r, rampStep, stepGoal_r);
         else if (target_r > stepGoal_r)
            targetNxt = subClamp(target_r, rampStep, stepGoal_r);
         busyNxt = (targetNxt != stepGoal_r);
      end
   end

   // 3-wire latch and run start
   wire runReq = threeWire ? ((startClean && !startPrev_r) || runActive) && stopHeld : startClean;
   wire dwellDone = (dwellCnt_r >= dwell_time);
   wire [FW-1:0] dwellF = (dwell_frequency < DWELL_FREQ_MIN) ? DWELL_FREQ_MIN : dwell_frequency;

   // slip arithmetic, poles clamped to legal range
   wire [3:0] poles = (motor_pole_count < POLES_MIN) ? POLES_MIN :
                      ((motor_pole_count > POLES_MAX) ? POLES_MAX : motor_pole_count);
   wire [31:0] syncHundredths = (32'(ratedRpm) * 32'(poles) * 32'd100) / 32'(SLIP_DIVISOR);
   wire [31:0] slipWide = (32'(ratedFreq) > syncHundredths) ? 32'(ratedFreq) - syncHundredths : 32'h0;
   wire slipOn = (control_mode_select == CTRL_SLIP_COMP);

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         upPrev_r <= 1'b0;
         downPrev_r <= 1'b0;
         startPrev_r <= 1'b0;
         holdCnt_r <= 32'h0;
         holdDone_r <= 1'b0;
         tickCnt_r <= 32'h0;
         target_r <= '0;
         stepGoal_r <= '0;
         stepBusy_r <= 1'b0;
         savedFreq <= '0;
      end
      else
      begin
         upPrev_r <= upIn;
         downPrev_r <= downIn;
         startPrev_r <= startClean;
         tickCnt_r <= tick ? 32'h0 : tickCnt_r + 32'h1;
         target_r <= targetNxt;
         stepGoal_r <= goalNxt;
         stepBusy_r <= busyNxt;
         if (anyRise || !anyHeld)
         begin
            holdCnt_r <= 32'h0;
            holdDone_r <= 1'b0;
         end
         // counter parks at the limit so holdDone stays up while held
         else if (holdCnt_r >= 32'(HOLD_CNT - 1))
            holdDone_r <= 1'b1;
         else
            holdCnt_r <= holdCnt_r + 32'h1;
         // stop saves nothing new: only falling edges store the value
         if (updownSaveEnable && udDefined && (upFall || downFall))
            savedFreq <= target_r;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         runState_r <= RUN_IDLE;
         dwellCnt_r <= 8'h0;
         runActive <= 1'b0;
         outFreq <= '0;
      end
      else
      begin
         runActive <= runReq;
         case (runState_r)
            RUN_IDLE:
            begin
               dwellCnt_r <= 8'h0;
               outFreq <= '0;
               if (runReq)
                  runState_r <= RUN_DWELL;
            end
            RUN_DWELL:
            begin
               outFreq <= dwellF;
               // dwell_time counts whole ticks; scale TICK_CNT to suit
               if (tick)
                  dwellCnt_r <= dwellCnt_r + 8'h1;
               if (!runReq)
                  runState_r <= RUN_IDLE;
               else if (dwellDone)
                  runState_r <= RUN_ACTIVE;
            end
            RUN_ACTIVE:
            begin
               outFreq <= freqRef;
               if (!runReq)
                  runState_r <= RUN_IDLE;
            end
            default:
               runState_r <= RUN_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!nrst)
      begin
         freqRef <= '0;
         slipCompActive <= 1'b0;
         rated_slip_freq <= '0;
         inertiaClass <= INERTIA_LOW;
         pidOutFreq <= PID_LOW_DEFAULT;
         pidBypassed <= 1'b0;
      end
      else
      begin
         freqRef <= target_r;
         slipCompActive <= slipOn;
         rated_slip_freq <= slipWide[FW-1:0];
         inertiaClass <= (load_inertia_code == 2'h0) ? INERTIA_LOW :
                         ((load_inertia_code == 2'h1) ? INERTIA_TEN : INERTIA_HIGH);
         pidOutFreq <= clampf(pidRawFreq, pid_out_low_limit, pid_out_high_limit);
         pidBypassed <= !pidEnable || bypassIn;
      end
   end
endmodule

// >>> tb/udfr_buttons.sv
`timescale 1ns/1ps
module udfr_buttons #(
   parameter int MIN_CYC = 8
) (
   // clock
   input wire logic sys_clk,
   // press requests, contact levels
   input wire logic [2:0] cmd,
   output logic [2:0] btn
);
   // press width scaled down with the debounce count
   int hold[3] = '{0, 0, 0};
   always @(posedge sys_clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         if (cmd[i])
         begin
            btn[i] <= 1'b1;
            hold[i] <= MIN_CYC;
         end
         else if (hold[i] > 0)
            hold[i] <= hold[i] - 1;
         else
            btn[i] <= 1'b0;
      end
   end
endmodule

// >>> tb/udfr_checker_asserts.sv
`timescale 1ns/1ps
module udfr_checker
   import udfr_pkg::*;
#(
   parameter int FW = FREQ_W
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic nrst,
   // settings
   input wire logic [3:0] freqSetMethod,
   input wire logic [FW-1:0] maxFreq,
   input wire logic [FW-1:0] dwell_frequency,
   input wire logic [7:0] dwell_time,
   input wire logic [1:0] control_mode_select,
   input wire logic [FW-1:0] ratedFreq,
   input wire logic [15:0] ratedRpm,
   input wire logic [3:0] motor_pole_count,
   input wire logic [1:0] load_inertia_code,
   input wire logic [FW-1:0] pidRawFreq,
   input wire logic [FW-1:0] pid_out_high_limit,
   input wire logic [FW-1:0] pid_out_low_limit,
   input wire logic pidEnable,
   // outputs
   input wire logic [FW-1:0] freqRef,
   input wire logic [FW-1:0] outFreq,
   input wire logic runActive,
   input wire logic slipCompActive,
   input wire logic [FW-1:0] rated_slip_freq,
   input wire logic [1:0] inertiaClass,
   input wire logic [FW-1:0] pidOutFreq,
   input wire logic pidBypassed
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   wire logic [31:0] syncTerm = 32'(ratedRpm) * motor_pole_count * 100 / SLIP_DIVISOR;
   wire logic [FW-1:0] slipExp = ratedFreq - syncTerm[FW-1:0];
   wire logic [FW-1:0] hiLim = pid_out_high_limit;
   wire logic [FW-1:0] loLim = pid_out_low_limit;
   wire logic [FW-1:0] pidExp = pidRawFreq > hiLim ? hiLim : (pidRawFreq < loLim ? loLim : pidRawFreq);
   wire logic [FW-1:0] dwellExp = dwell_frequency < DWELL_FREQ_MIN ? DWELL_FREQ_MIN : dwell_frequency;
   sequence s_pid_quiet;
      $stable(pidRawFreq) && $stable(hiLim) && $stable(loLim);
   endsequence
   sequence s_motor_quiet;
      $stable(ratedFreq) && $stable(ratedRpm) && $stable(motor_pole_count);
   endsequence
   a_method_gate: assert property ((freqSetMethod != FRQ_METHOD_UPDOWN)[*4] |-> $stable(freqRef))
      else $error("reference moved outside up-down method");
   a_ref_ceiling: assert property ($stable(maxFreq) |-> freqRef <= maxFreq)
      else $error("reference above max frequency");
   a_idle_zero: assert property ((!runActive)[*3] |-> outFreq == '0)
      else $error("output frequency while not running");
   a_dwell_start: assert property ($rose(runActive) && dwell_time != 8'h00 |-> ##[0:2] outFreq == dwellExp)
      else $error("no dwell frequency at start");
   a_slip_gate: assert property ($stable(control_mode_select)[*3] |->
      slipCompActive == (control_mode_select == CTRL_SLIP_COMP))
      else $error("slip compensation enable wrong");
   a_slip_value: assert property (s_motor_quiet[*4] |-> rated_slip_freq == slipExp)
      else $error("rated slip frequency wrong");
   a_inertia_decode: assert property (($stable(load_inertia_code) && load_inertia_code != 2'h3)[*3] |->
      inertiaClass == load_inertia_code)
      else $error("inertia class wrong");
   a_pid_clamp: assert property (s_pid_quiet[*4] |-> pidOutFreq == pidExp)
      else $error("PID output not clamped");
   a_pid_bypass: assert property ((!pidEnable)[*3] |-> pidBypassed)
      else $error("PID not bypassed when disabled");
endmodule
bind udfr_updown_freq_ref udfr_checker #(.FW(FW)) chk (.sys_clk, .nrst, .freqSetMethod, .maxFreq,
   .dwell_frequency, .dwell_time, .control_mode_select, .ratedFreq, .ratedRpm, .motor_pole_count,
   .load_inertia_code, .pidRawFreq, .pid_out_high_limit, .pid_out_low_limit, .pidEnable, .freqRef,
   .outFreq, .runActive, .slipCompActive, .rated_slip_freq, .inertiaClass, .pidOutFreq, .pidBypassed);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import udfr_pkg::*;
   logic sys_clk = 1'b0, nrst = 1'b0, updownSaveEnable = 1'b1, freqLimitEnable = 1'b1, pidEnable = 1'b1;
   logic [2:0] cmd = 3'h0;
   logic [3:0] freqSetMethod = 4'h0, motor_pole_count = POLES_DEFAULT;
   logic [4:0] terminal_seven_function = FUNC_UP, terminal_eight_function = FUNC_DOWN;
   logic [1:0] updown_mode_select = UDMODE_RAMP, control_mode_select = 2'h0, load_inertia_code = 2'h0;
   logic [15:0] updown_step_freq = 16'h01F4, maxFreq = 16'h1770, upperLimit = 16'h07D0, lowerLimit = 16'h012C;
   logic [15:0] rampStep = 16'h0064, dwell_frequency = 16'h01F4, ratedFreq = 16'h1770, ratedRpm = 16'h06CC;
   logic [15:0] pidRawFreq = 16'h1B58, pid_out_high_limit = PID_HIGH_DEFAULT, pid_out_low_limit = PID_LOW_DEFAULT;
   logic [7:0] dwell_time = 8'h32;
   wire logic [2:0] btn;
   wire logic [15:0] freqRef, outFreq, savedFreq, rated_slip_freq, pidOutFreq;
   wire logic runActive, slipCompActive, pidBypassed;
   wire logic [1:0] inertiaClass;
   int bad_count = 0, checked = 0, cyc = 0;
   udfr_buttons buttons (.sys_clk, .cmd, .btn);
   udfr_updown_freq_ref #(.HOLD_CNT(200), .DEB_CNT(2), .TICK_CNT(4)) dut (.sys_clk, .nrst, .termSeven(btn[0]),
      .termEight(btn[1]), .startButton(btn[2]), .freqSetMethod, .terminal_seven_function, .terminal_eight_function,
      .updown_mode_select, .updown_step_freq, .updownSaveEnable, .maxFreq, .freqLimitEnable, .upperLimit,
      .lowerLimit, .rampStep, .dwell_frequency, .dwell_time, .control_mode_select, .ratedFreq, .ratedRpm,
      .motor_pole_count, .load_inertia_code, .pidRawFreq, .pid_out_high_limit, .pid_out_low_limit, .pidEnable,
      .freqRef, .outFreq, .savedFreq, .runActive, .slipCompActive, .rated_slip_freq, .inertiaClass, .pidOutFreq,
      .pidBypassed);
   initial forever #12.5 sys_clk = ~sys_clk;
   task tick(int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task chk(string what, logic [15:0] seen, logic [15:0] exp);
      checked++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task press(int k, int n);
      tick(1);
      cmd[k] <= 1'b1;
      tick(n);
      cmd[k] <= 1'b0;
   endtask
   // bounded wait so a stuck reference cannot hang the run
   task wait_ref(logic [15:0] e);
      for (int k = 0; k < 600 && freqRef !== e; k++)
         tick(1);
      tick(8);
   endtask
   task t_gate_and_ramp();
      press(0, 40);
      tick(20);
      chk("gated", freqRef, 16'h0000);
      tick(1);
      freqSetMethod <= FRQ_METHOD_UPDOWN;
      cmd[0] <= 1'b1;
      wait_ref(upperLimit);
      chk("rampUp", freqRef, 16'h07D0);
      cmd[0] <= 1'b0;
      cmd[1] <= 1'b1;
      wait_ref(lowerLimit);
      chk("rampDown", freqRef, 16'h012C);
      cmd[1] <= 1'b0;
   endtask
   task t_step();
      tick(1);
      updown_mode_select <= UDMODE_STEP;
      press(0, 40);
      wait_ref(16'h0320);
      // the release must clear the contact hold and debouncer before the save lands
      tick(12);
      chk("stepUp", freqRef, 16'h0320);
      chk("saveUp", savedFreq, 16'h0320);
      press(1, 40);
      wait_ref(16'h012C);
      tick(12);
      chk("stepDown", freqRef, 16'h012C);
      chk("saveDown", savedFreq, 16'h012C);
   endtask
   task t_ignore();
      tick(1);
      rampStep <= 16'h000A;
      press(0, 1);
      tick(20);
      press(0, 1);
      tick(300);
      chk("stepIgnored", freqRef, 16'h0320);
      tick(1);
      rampStep <= 16'h0064;
   endtask
   task t_combo();
      tick(1);
      updown_mode_select <= UDMODE_COMBO;
      freqLimitEnable <= 1'b0;
      cmd[0] <= 1'b1;
      tick(100);
      chk("comboStep", freqRef, 16'h0514);
      wait_ref(maxFreq);
      chk("comboRamp", freqRef, 16'h1770);
      cmd[0] <= 1'b0;
   endtask
   task t_three_wire();
      tick(1);
      terminal_eight_function <= FUNC_STOP3W;
      dwell_frequency <= 16'h0005;
      cmd[1] <= 1'b1;
      tick(10);
      press(2, 1);
      tick(25);
      chk("runLatch", 16'(runActive), 16'h0001);
      chk("dwell", outFreq, DWELL_FREQ_MIN);
      tick(230);
      chk("afterDwell", outFreq, 16'h1770);
      tick(1);
      cmd[1] <= 1'b0;
      tick(15);
      chk("runDrop", 16'(runActive), 16'h0000);
      chk("stopKeeps", savedFreq, 16'h1770);
   endtask
   task t_static();
      for (int i = 0; i < 3; i++)
      begin
         tick(1);
         load_inertia_code <= 2'(i);
         tick(4);
         chk("inertia", 16'(inertiaClass), 16'(i));
      end
      chk("slipOff", 16'(slipCompActive), 16'h0000);
      chk("slip4", rated_slip_freq, 16'h00C8);
      chk("pidHigh", pidOutFreq, 16'h1770);
      tick(1);
      control_mode_select <= CTRL_SLIP_COMP;
      ratedRpm <= 16'h0474;
      motor_pole_count <= 4'h6;
      pidRawFreq <= 16'h000A;
      tick(6);
      chk("slipOn", 16'(slipCompActive), 16'h0001);
      chk("slip6", rated_slip_freq, 16'h012C);
      chk("pidLow", pidOutFreq, 16'h0032);
      chk("bypassOff", 16'(pidBypassed), 16'h0000);
      tick(1);
      terminal_seven_function <= FUNC_PID_BYPASS;
      cmd[0] <= 1'b1;
      tick(15);
      chk("bypassOn", 16'(pidBypassed), 16'h0001);
      tick(1);
      cmd[0] <= 1'b0;
      tick(20);
      chk("bypassRelease", 16'(pidBypassed), 16'h0000);
      pidEnable <= 1'b0;
      tick(3);
      chk("pidOff", 16'(pidBypassed), 16'h0001);
   endtask
   task finish_test();
      $display("checked %0d bad_count %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge sys_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         bad_count++;
         finish_test();
      end
   end
   initial
   begin
      tick(16);
      nrst <= 1'b1;
      tick(10);
      t_gate_and_ramp();
      t_step();
      t_ignore();
      t_combo();
      t_three_wire();
      t_static();
      finish_test();
   end
endmodule
